// ### rtl/siw_pkg.sv
/*
  Shared constants and types for the synthesizer serial write control.
  Assumes a single mclk domain; every user imports the whole package.
*/
package siw_pkg;

  // Fixed upper address bits; the two low address bits come from pins.
  localparam logic [4:0] SIW_ADDR_FIXED = 5'h18;
  localparam logic [3:0] SIW_BYTE_BITS  = 4'h8;

  // Leading bit of a data byte: 0 for divider, 1 for control.
  localparam int SIW_MARK_POS = 7;

  // Control byte fields.
  localparam int SIW_CP_POS   = 6;
  localparam int SIW_T1_POS   = 5;
  localparam int SIW_T0_POS   = 4;
  localparam int SIW_BSC_POS  = 3;
  localparam int SIW_B1_POS   = 2;
  localparam int SIW_B0_POS   = 1;
  localparam int SIW_OS_POS   = 0;

  // Port byte fields; bit 3 is ignored.
  localparam int SIW_P7_POS   = 7;
  localparam int SIW_P6_POS   = 6;
  localparam int SIW_P5_POS   = 5;
  localparam int SIW_P4_POS   = 4;
  localparam int SIW_P2_POS   = 2;
  localparam int SIW_P1_POS   = 1;
  localparam int SIW_P0_POS   = 0;

  // Reset values.
  localparam logic [7:0]  SIW_CTL_RST   = 8'h00;
  localparam logic [7:0]  SIW_PORT_RST  = 8'h00;
  localparam logic [14:0] SIW_RATIO_RST = 15'h0000;
  localparam logic [3:0]  SIW_OC_RST    = 4'h0;
  localparam logic [2:0]  SIW_EF_RST    = 3'h7;

  // Dividers.
  localparam int SIW_REF_DIV  = 512;
  localparam int SIW_PRESCALE = 8;
  localparam logic [8:0] SIW_REF_LAST = 9'(SIW_REF_DIV - 1);
  localparam logic [2:0] SIW_PRE_LAST = 3'(SIW_PRESCALE - 1);

  // Band levels chosen by ports 7, 5 and 4.
  localparam logic [2:0] SIW_BANDP_LOW  = 3'h6;
  localparam logic [2:0] SIW_BANDP_MID  = 3'h5;
  localparam logic [2:0] SIW_BANDP_HIGH = 3'h3;
  localparam logic [1:0] SIW_BAND_LOW   = 2'h0;
  localparam logic [1:0] SIW_BAND_MID   = 2'h1;
  localparam logic [1:0] SIW_BAND_HIGH  = 2'h2;
  localparam logic [1:0] SIW_BAND_TOP   = 2'h3;

  typedef enum logic [1:0] {SIW_RX_IDLE, SIW_RX_SHIFT, SIW_RX_ACK,
                            SIW_RX_SKIP} siw_rx_t;
  typedef enum logic [1:0] {SIW_EXP_CLASS, SIW_EXP_DIV_LO,
                            SIW_EXP_PORT} siw_expect_t;

endpackage

// ### rtl/siw_byte_if.sv
/*
  Byte hand-off between the serial receiver and the control logic.
  Assumes both ends run on mclk.
*/
interface siw_byte_if;
  logic [7:0] data;
  logic       strobe;
  logic       frame_start;
  logic [1:0] addr_bits;

  modport rx  (output data, strobe, frame_start, input addr_bits);
  modport ctl (input data, strobe, frame_start, output addr_bits);
endinterface

// ### rtl/siw_i2c_rx.sv
/*
  Write-only two-wire receiver: start and stop detection, address match,
  byte shifting and acknowledge. Assumes scl and sda come from pins and
  that mclk is several times faster than the serial clock.
*/
module siw_i2c_rx
  import siw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  siw_byte_if.rx    bus
);

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  siw_rx_t    state_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic       addr_phase_q;
  logic       strobe_q;
  logic       frame_q;

  // Two stages tame the pins; the third stage only serves edge finding.
  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  wire scl_rise   = scl_q[1] & ~scl_q[2];
  wire scl_fall   = ~scl_q[1] & scl_q[2];
  wire scl_high   = scl_q[1] & scl_q[2];
  wire start_seen = scl_high & sda_q[2] & ~sda_q[1];
  wire stop_seen  = scl_high & ~sda_q[2] & sda_q[1];
  wire byte_done  = scl_fall && (cnt_q == SIW_BYTE_BITS);
  // A read request is never matched, so the read phase is not answered.
  wire addr_match = (shift_q[7:1] == {SIW_ADDR_FIXED, bus.addr_bits})
                    && !shift_q[0];

  // Receiver sequence; a stop returns to idle, a start always restarts.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q      <= SIW_RX_IDLE;
      shift_q      <= 8'h00;
      cnt_q        <= 4'h0;
      addr_phase_q <= 1'b0;
      strobe_q     <= 1'b0;
      frame_q      <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      frame_q  <= 1'b0;
      if (start_seen) begin
        state_q      <= SIW_RX_SHIFT;
        cnt_q        <= 4'h0;
        addr_phase_q <= 1'b1;
      end else if (stop_seen) begin
        state_q <= SIW_RX_IDLE;                              // [R6]
      end else begin
        case (state_q)
          SIW_RX_SHIFT: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q[1]};
              cnt_q   <= cnt_q + 4'h1;
            end else if (byte_done) begin
              if (!addr_phase_q) begin
                strobe_q <= 1'b1;                            // [R3]
                state_q  <= SIW_RX_ACK;
              end else if (addr_match) begin
                frame_q <= 1'b1;                             // [R1] [R2]
                state_q <= SIW_RX_ACK;
              end else begin
                state_q <= SIW_RX_SKIP;
              end
            end
          end
          SIW_RX_ACK: begin
            if (scl_fall) begin
              state_q      <= SIW_RX_SHIFT;                  // [R6]
              cnt_q        <= 4'h0;
              addr_phase_q <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Acknowledge pulls the line low for one whole serial clock low-high-low.
  assign sda_out         = 1'b0;
  assign sda_oe          = (state_q == SIW_RX_ACK);          // [R3]
  assign bus.data        = shift_q;
  assign bus.strobe      = strobe_q;
  assign bus.frame_start = frame_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  ack_on_byte_a: assert property ( // [R3]
    bus.strobe |-> sda_oe && !sda_out ##1 sda_oe)
    else $error("data byte not acknowledged");
  addr_check_a: assert property ( // [R2]
    bus.frame_start |-> shift_q[7:3] == SIW_ADDR_FIXED
      && shift_q[2:1] == bus.addr_bits && !shift_q[0])
    else $error("address accepted without match");
  continue_rx_a: assert property ( // [R6]
    sda_oe && scl_fall && !start_seen && !stop_seen
      |=> state_q == SIW_RX_SHIFT && cnt_q == 4'h0)
    else $error("receiver did not continue after acknowledge");

endmodule

// ### rtl/siw_write_ctl.sv
/*
  Write-side control of a serial-programmed frequency synthesizer: byte
  classification, divider ratio, control and port registers, band select,
  reference and input dividers. Assumes all pin inputs are asynchronous
  to mclk and toggle well below half the mclk rate.
*/
// Functional notes
// [R1] Answer one 7-bit address followed by a write/read direction bit.
// [R2] Address byte is 1,1,0,0,0, two pin bits, then direction 0.
// [R3] Accept four data bytes per transfer and acknowledge each one low.
// [R4] Controller starts partial writes only with upper divider or control.
// [R5] First data byte leading 0 means divider, 1 means control and ports.
// [R6] Keep taking data bytes without re-addressing until STOP.
// [R7] Divider bytes form a 15-bit ratio, upper seven bits first.
// [R8] Control byte: marker, pump current, two test bits, band src, band.
// [R9] Port byte: ports 7,6,5,4, ignored bit, ports 2,1,0.
// [R10] At power-on open-collector ports float, emitter ports drive high.
// [R11] Band output follows band code or ports 7,5,4 by band source.
// [R12] Comparison reference is the crystal clock divided by 512.
// [R13] Input signal is prescaled by 8 ahead of the ratio divider.
// [R14] In test routing, port 2 outputs the divided input frequency.
// [R15] Pump tristate bit at 1 floats the charge-pump output.
// [R16] Amplifier-off bit at 1 switches off the varactor drive.
// [R17] Band source 0 uses band code bits, 1 uses ports 7,5,4.
// [R18] Open-collector bit 1 is active; emitter-follower bit 1 drives low.
// [R19] After a completed pair, the next byte is classified afresh.
module siw_write_ctl
  import siw_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_pin_bit_hi,
  input  wire logic        addr_pin_bit_lo,
  input  wire logic        xtal_in,
  input  wire logic        rf_in,
  output logic             ref_out,
  output logic             div_out,
  output logic [14:0]      ratio_out,
  output logic             pump_current_sel,
  output logic             pump_out_en,
  output logic             varactor_drive_out_en,
  output logic [1:0]       band_select_out,
  output logic [3:0]       port_oc_oe,
  output logic [2:0]       port_ef_out
);

  siw_byte_if byte_bus ();

  siw_i2c_rx u_rx (
    .mclk    (mclk),
    .reset   (reset),
    .scl     (scl),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .bus     (byte_bus.rx)
  );

  logic [2:0]  xtal_q;
  logic [2:0]  rf_q;
  logic [1:0]  ahi_q;
  logic [1:0]  alo_q;

  // Pin synchronisers; the address straps change only at board level.
  always_ff @(posedge mclk) begin
    if (reset) begin
      xtal_q <= 3'h0;
      rf_q   <= 3'h0;
      ahi_q  <= 2'h0;
      alo_q  <= 2'h0;
    end else begin
      xtal_q <= {xtal_q[1:0], xtal_in};
      rf_q   <= {rf_q[1:0], rf_in};
      ahi_q  <= {ahi_q[0], addr_pin_bit_hi};
      alo_q  <= {alo_q[0], addr_pin_bit_lo};
    end
  end

  assign byte_bus.addr_bits = {ahi_q[1], alo_q[1]};         // [R2]

  wire xtal_rise = xtal_q[1] & ~xtal_q[2];
  wire rf_rise   = rf_q[1] & ~rf_q[2];

  siw_expect_t exp_q;
  logic [6:0]  upper_q;
  logic [14:0] ratio_q;
  logic [7:0]  ctl_q;
  logic [7:0]  port_q;

  wire [7:0] rx_data  = byte_bus.data;
  wire       rx_stb   = byte_bus.strobe;
  wire       is_ctl   = rx_data[SIW_MARK_POS];               // [R5]

  // Byte sequencing. The upper divider bits are staged and the ratio is
  // committed only with the lower byte, so the loop never sees half a
  // new ratio during a sweep.
  always_ff @(posedge mclk) begin
    if (reset) begin
      exp_q   <= SIW_EXP_CLASS;
      upper_q <= 7'h00;
      ratio_q <= SIW_RATIO_RST;
      ctl_q   <= SIW_CTL_RST;
      port_q  <= SIW_PORT_RST;
    end else if (byte_bus.frame_start) begin
      exp_q <= SIW_EXP_CLASS;                                // [R4]
    end else if (rx_stb) begin
      case (exp_q)
        SIW_EXP_CLASS: begin
          if (is_ctl) begin
            ctl_q <= rx_data;                                // [R8]
            exp_q <= SIW_EXP_PORT;                           // [R5]
          end else begin
            upper_q <= rx_data[6:0];                         // [R7]
            exp_q   <= SIW_EXP_DIV_LO;                       // [R5]
          end
        end
        SIW_EXP_DIV_LO: begin
          ratio_q <= {upper_q, rx_data};                     // [R7]
          exp_q   <= SIW_EXP_CLASS;                          // [R19]
        end
        SIW_EXP_PORT: begin
          port_q <= rx_data;                                 // [R9]
          exp_q  <= SIW_EXP_CLASS;                           // [R19]
        end
        default: begin
          exp_q <= SIW_EXP_CLASS;
        end
      endcase
    end
  end

  logic [8:0]  ref_cnt_q;
  logic [2:0]  pre_cnt_q;
  logic [14:0] div_cnt_q;

  // Ratio divider counts prescaled input periods; a ratio of 0 or 1
  // simply wraps on every prescaled period.
  wire        pre_tick = rf_rise && (pre_cnt_q == SIW_PRE_LAST);
  wire [15:0] div_next = {1'b0, div_cnt_q} + 16'h0001;
  wire        div_last = div_next >= {1'b0, ratio_q};
  wire        div_high = div_cnt_q < {1'b0, ratio_q[14:1]};

  // Reference and input dividers, all counted on pin edges.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ref_cnt_q <= 9'h000;
      pre_cnt_q <= 3'h0;
      div_cnt_q <= 15'h0000;
    end else begin
      if (xtal_rise) begin
        ref_cnt_q <= ref_cnt_q + 9'h001;                     // [R12]
      end
      if (rf_rise) begin
        pre_cnt_q <= pre_cnt_q + 3'h1;                       // [R13]
      end
      if (pre_tick) begin
        div_cnt_q <= div_last ? 15'h0000 : div_next[14:0];   // [R13]
      end
    end
  end

  // Band level from ports 7, 5 and 4; other combinations give the top.
  wire [2:0] band_ports = {port_q[SIW_P7_POS], port_q[SIW_P5_POS],
                           port_q[SIW_P4_POS]};
  wire [1:0] band_by_port =
    (band_ports == SIW_BANDP_LOW)  ? SIW_BAND_LOW  :
    (band_ports == SIW_BANDP_MID)  ? SIW_BAND_MID  :
    (band_ports == SIW_BANDP_HIGH) ? SIW_BAND_HIGH : SIW_BAND_TOP;
  wire [1:0] band_by_code = {ctl_q[SIW_B1_POS], ctl_q[SIW_B0_POS]};
  wire [1:0] band_d = ctl_q[SIW_BSC_POS] ? band_by_port      // [R11]
                                         : band_by_code;     // [R17]

  // Port drive; test routing puts the divided signals on ports 2 and 6.
  wire       test_route = ctl_q[SIW_T1_POS];
  wire       ref_d      = ref_cnt_q[8];                      // [R12]
  wire [3:0] oc_d = {test_route ? ~ref_out : port_q[SIW_P6_POS],
                     test_route ? ~div_out : port_q[SIW_P2_POS], // [R14]
                     port_q[SIW_P1_POS], port_q[SIW_P0_POS]};    // [R18]
  wire [2:0] ef_d = ~band_ports;                             // [R18]

  // All pin outputs but the data line leave from flip-flops, one cycle behind the registers.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ref_out               <= 1'b0;
      div_out               <= 1'b0;
      ratio_out             <= SIW_RATIO_RST;
      pump_current_sel      <= 1'b0;
      pump_out_en           <= 1'b1;
      varactor_drive_out_en <= 1'b1;
      band_select_out       <= SIW_BAND_LOW;
      port_oc_oe            <= SIW_OC_RST;                   // [R10]
      port_ef_out           <= SIW_EF_RST;                   // [R10]
    end else begin
      ref_out               <= ref_d;
      div_out               <= div_high;
      ratio_out             <= ratio_q;
      pump_current_sel      <= ctl_q[SIW_CP_POS];
      pump_out_en           <= ~ctl_q[SIW_T0_POS];           // [R15]
      varactor_drive_out_en <= ~ctl_q[SIW_OS_POS];           // [R16]
      band_select_out       <= band_d;
      port_oc_oe            <= oc_d;
      port_ef_out           <= ef_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  class_div_a: assert property ( // [R5]
    rx_stb && exp_q == SIW_EXP_CLASS && !rx_data[SIW_MARK_POS]
      |=> exp_q == SIW_EXP_DIV_LO && upper_q == $past(rx_data[6:0]))
    else $error("divider byte misclassified");
  class_ctl_a: assert property ( // [R8]
    rx_stb && exp_q == SIW_EXP_CLASS && rx_data[SIW_MARK_POS]
      |=> exp_q == SIW_EXP_PORT && ctl_q == $past(rx_data))
    else $error("control byte misclassified");
  ratio_load_a: assert property ( // [R7]
    rx_stb && exp_q == SIW_EXP_DIV_LO
      |=> ratio_q == {$past(upper_q), $past(rx_data)}
      ##1 ratio_out == $past(ratio_q))
    else $error("ratio not loaded from divider pair");
  pair_reclass_a: assert property ( // [R19]
    rx_stb && exp_q != SIW_EXP_CLASS |=> exp_q == SIW_EXP_CLASS)
    else $error("no reclassification after pair");
  port_load_a: assert property ( // [R9]
    rx_stb && exp_q == SIW_EXP_PORT && !test_route |-> ##2
      port_ef_out == ~{$past(rx_data[7], 2), $past(rx_data[5], 2),
                       $past(rx_data[4], 2)}
      && port_oc_oe[1:0] == $past(rx_data[1:0], 2))
    else $error("port byte not driven to pins");
  por_ports_a: assert property ( // [R10]
    $past(reset) |-> port_oc_oe == SIW_OC_RST
      && port_ef_out == SIW_EF_RST)
    else $error("ports not at power-on state");
  band_code_a: assert property ( // [R17]
    !ctl_q[SIW_BSC_POS] |=> band_select_out == $past(band_by_code))
    else $error("band output not following band code");
  ref_wrap_a: assert property ( // [R12]
    xtal_rise && ref_cnt_q == SIW_REF_LAST
      |=> ref_cnt_q == 9'h000 ##1 !ref_out)
    else $error("reference divider wrap wrong");
  prescale_gate_a: assert property ( // [R13]
    rf_rise && pre_cnt_q != SIW_PRE_LAST |=> $stable(div_cnt_q))
    else $error("ratio divider advanced without prescale");
  test_route_a: assert property ( // [R14]
    test_route |=> port_oc_oe[2] == ~$past(div_out))
    else $error("port 2 not carrying divided input");
  pump_hiz_a: assert property ( // [R15]
    ctl_q[SIW_T0_POS] |=> !pump_out_en)
    else $error("pump not floated");
  amp_off_a: assert property ( // [R16]
    ctl_q[SIW_OS_POS] |=> !varactor_drive_out_en)
    else $error("varactor drive not switched off");

  // Counterparts of the checks above: a cleared control bit must give the
  // pin back to normal use, otherwise a stuck enable would pass unseen.
  pump_on_a: assert property ( // [R15]
    !ctl_q[SIW_T0_POS] |=> pump_out_en)
    else $error("pump floated with test bit clear");
  amp_on_a: assert property ( // [R16]
    !ctl_q[SIW_OS_POS] |=> varactor_drive_out_en)
    else $error("varactor drive off with control bit clear");
  port_route_a: assert property ( // [R14]
    test_route |=> port_oc_oe[3] == ~$past(ref_out))
    else $error("port 6 not carrying reference");
  port_level_a: assert property ( // [R18]
    !test_route |=> port_oc_oe[3] == $past(port_q[SIW_P6_POS])
      && port_oc_oe[2] == $past(port_q[SIW_P2_POS]))
    else $error("open-collector ports not following port bits");
  ef_level_a: assert property ( // [R18]
    1'b1 |=> port_ef_out == ~$past(band_ports))
    else $error("emitter ports not inverse of port bits");

  // Band decoding from ports, one check per decoded pattern and one for
  // the patterns that fall back to the top level.
  band_low_a: assert property ( // [R11]
    ctl_q[SIW_BSC_POS] && band_ports == SIW_BANDP_LOW
      |=> band_select_out == SIW_BAND_LOW)
    else $error("port pattern did not give lowest band");
  band_mid_a: assert property ( // [R11]
    ctl_q[SIW_BSC_POS] && band_ports == SIW_BANDP_MID
      |=> band_select_out == SIW_BAND_MID)
    else $error("port pattern did not give middle band");
  band_high_a: assert property ( // [R11]
    ctl_q[SIW_BSC_POS] && band_ports == SIW_BANDP_HIGH
      |=> band_select_out == SIW_BAND_HIGH)
    else $error("port pattern did not give high band");
  band_top_a: assert property ( // [R11]
    ctl_q[SIW_BSC_POS] && band_ports != SIW_BANDP_LOW
      && band_ports != SIW_BANDP_MID && band_ports != SIW_BANDP_HIGH
      |=> band_select_out == SIW_BAND_TOP)
    else $error("other port pattern did not give top band");

  // Sequencing: the upper byte alone never moves the ratio, a new frame
  // always restarts classification, and the ratio divider wraps to zero.
  ratio_hold_a: assert property ( // [R7]
    rx_stb && exp_q == SIW_EXP_CLASS |=> $stable(ratio_q))
    else $error("ratio changed before lower byte");
  frame_class_a: assert property ( // [R5]
    byte_bus.frame_start |=> exp_q == SIW_EXP_CLASS)
    else $error("new frame did not restart classification");
  div_wrap_a: assert property ( // [R13]
    pre_tick && div_last |=> div_cnt_q == 15'h0000)
    else $error("ratio divider did not wrap");

endmodule

// ### bench/siw_bus_ctl_model.sv
/*
  Behavioural model of the serial bus controller that programs the block.
  Assumes an external pull-up on the data line; the model only pulls low.
  The serial clock stands high between frames, as an idle bus does.
*/
module siw_bus_ctl_model
  import siw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus released and idle from time zero.
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Half a link clock period of 80 ns; changes land just after an edge.
  task automatic half();
    repeat (5) @(posedge mclk);
    #1;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start_c();
    sda_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b1;
    half();
    scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop_c();
    sda_oe = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b0;
    half();
  endtask

  // One byte, most significant bit first, then the acknowledge slot.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = !b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
    end
    sda_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    ack = (sda === 1'b0);
    scl = 1'b0;
    // Extra low time lets the device let go before the next bit.
    half();
  endtask
endmodule

// ### bench/synth_i2c_write_control_tb_top.sv
/*
  Self-checking bench for the synthesizer write control.
  Assumes the design resets synchronously and acknowledges address 1100_010.
*/
module synth_i2c_write_control_tb_top
  import siw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, reset, scl, m_oe, xtal_in, rf_in;
  logic        sda_out, sda_oe, ref_out, div_out;
  logic        pump_current_sel, pump_out_en, varactor_drive_out_en;
  logic        addr_pin_bit_hi, addr_pin_bit_lo;
  logic [14:0] ratio_out;
  logic [1:0]  band_select_out;
  logic [3:0]  port_oc_oe;
  logic [2:0]  port_ef_out;
  logic [7:0]  tick;
  int          mismatches, compares, cyc, n, p;
  // Wired data line: pulled up unless some party pulls it low.
  wire         sda_w = !(m_oe || (sda_oe && !sda_out));

  siw_write_ctl dut (.mclk, .reset, .scl, .sda_in(sda_w), .sda_out,
    .sda_oe, .addr_pin_bit_hi, .addr_pin_bit_lo, .xtal_in, .rf_in,
    .ref_out, .div_out, .ratio_out, .pump_current_sel, .pump_out_en,
    .varactor_drive_out_en, .band_select_out, .port_oc_oe, .port_ef_out);
  siw_bus_ctl_model m (.mclk, .sda(sda_w), .scl, .sda_oe(m_oe));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // Input signal period 4 mclk, crystal period 8 mclk, both off the edge.
  initial tick = 8'h00;
  always @(posedge mclk) begin
    #1;
    tick = tick + 8'h01;
    rf_in = tick[1];
    xtal_in = tick[2];
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One whole transfer: start, bytes, stop; returns the acknowledge count.
  task automatic send(input logic [7:0] q[$], output int acks);
    logic a;
    acks = 0;
    m.start_c();
    foreach (q[i]) begin
      m.put_byte(q[i], a);
      if (a) acks++;
    end
    m.stop_c();
  endtask

  // Cycles between two rising edges of the reference or divided output.
  task automatic period(input bit is_ref, output int pr);
    int  k, rises;
    logic pv, cv;
    k = 0;
    rises = 0;
    pr = 0;
    pv = is_ref ? ref_out : div_out;
    while (rises < 2 && k < 12000) begin
      @(posedge mclk);
      #2;
      k++;
      cv = is_ref ? ref_out : div_out;
      if (rises == 1) pr++;
      if (cv === 1'b1 && pv === 1'b0) rises++;
      pv = cv;
    end
    // A silent output is a failure even where no period is compared.
    if (rises < 2) begin
      mismatches++;
      $display("[FAIL] period rises expected 2 seen %0d", rises);
    end
  endtask

  function automatic logic [1:0] band_of(input logic [2:0] pat);
    case (pat)
      3'b110:  return 2'h0;
      3'b101:  return 2'h1;
      3'b011:  return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

  task automatic t_reset();
    chk("port_oc_oe", 16'(SIW_OC_RST), 16'(port_oc_oe));
    chk("port_ef_out", 16'(3'h7), 16'(port_ef_out));
    chk("ratio_out", 16'h0000, 16'(ratio_out));
    chk("pump_out_en", 16'h0001, 16'(pump_out_en));
    chk("varactor_en", 16'h0001, 16'(varactor_drive_out_en));
    chk("sda_oe", 16'h0000, 16'(sda_oe));
    $display("t_reset done");
  endtask

  // Wrong pin bits, then read direction: neither is acknowledged.
  task automatic t_addr();
    send('{8'hC0, 8'h12, 8'h34}, n);
    chk("acks wrong addr", 16'h0000, 16'(n));
    send('{8'hC5, 8'h12, 8'h34}, n);
    chk("acks read dir", 16'h0000, 16'(n));
    chk("ratio kept", 16'h0000, 16'(ratio_out));
    $display("t_addr done");
  endtask

  // Address plus four bytes in one transfer.
  task automatic t_full();
    send('{8'hC4, 8'h12, 8'h34, 8'hC0, 8'hF7}, n);
    chk("acks full", 16'h0005, 16'(n));
    chk("ratio", 16'h1234, 16'(ratio_out));
    chk("pump_current", 16'h0001, 16'(pump_current_sel));
    chk("oc ports", 16'h000F, 16'(port_oc_oe));
    chk("ef ports", 16'h0000, 16'(port_ef_out));
    $display("t_full done");
  endtask

  // Control first, then two divider pairs without a new address.
  task automatic t_sweep();
    send('{8'hC4, 8'h82, 8'h08, 8'h01, 8'h02, 8'h00, 8'h05}, n);
    chk("acks sweep", 16'h0007, 16'(n));
    chk("ratio swept", 16'h0005, 16'(ratio_out));
    chk("band code", 16'h0001, 16'(band_select_out));
    chk("ignored bit", 16'h0000, 16'(port_oc_oe));
    chk("ef ignored", 16'h0007, 16'(port_ef_out));
    $display("t_sweep done");
  endtask

  // Every band code, then the three decoded port patterns and one fallback with the port source.
  task automatic t_band();
    logic [2:0] pats[4] = '{3'b110, 3'b101, 3'b011, 3'b000};
    for (int b = 0; b < 4; b++) begin
      send('{8'hC4, 8'h80 | 8'(b << 1), 8'h00}, n);
      chk("band code", 16'(b), 16'(band_select_out));
    end
    foreach (pats[i]) begin
      send('{8'hC4, 8'h88, {pats[i][2], 1'b0, pats[i][1:0], 4'h0}}, n);
      chk("band ports", 16'(band_of(pats[i])), 16'(band_select_out));
    end
    $display("t_band done");
  endtask

  // Reference and divided periods at ratio 5.
  task automatic t_div();
    send('{8'hC4, 8'h80, 8'h00}, n);
    period(1'b1, p);
    chk("ref period", 16'(SIW_REF_DIV * 8), 16'(p));
    period(1'b0, p);
    chk("div period", 16'(SIW_PRESCALE * 5 * 4), 16'(p));
    $display("t_div done");
  endtask

  // Test routing, pump float and amplifier off together.
  task automatic t_test();
    send('{8'hC4, 8'hB1, 8'h00}, n);
    chk("pump_out_en", 16'h0000, 16'(pump_out_en));
    chk("varactor_en", 16'h0000, 16'(varactor_drive_out_en));
    period(1'b0, p);
    repeat (4) @(posedge mclk);
    #2;
    chk("div high", 16'h0001, 16'(div_out));
    chk("port 2 routed", 16'h0000, 16'(port_oc_oe[2]));
    send('{8'hC4, 8'h80, 8'h04}, n);
    chk("port 2 level", 16'h0001, 16'(port_oc_oe[2]));
    chk("pump back on", 16'h0001, 16'(pump_out_en));
    $display("t_test done");
  endtask

  initial begin
    reset = 1'b1;
    addr_pin_bit_hi = 1'b1;
    addr_pin_bit_lo = 1'b0;
    xtal_in = 1'b0;
    rf_in = 1'b0;
    mismatches = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    #1;
    t_reset();
    reset = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    t_addr();
    t_full();
    t_sweep();
    t_band();
    t_div();
    t_test();
    report_and_stop();
  end
endmodule
